// File: rtl/asr_seq_cfg.sv
/*
 * asr_seq_cfg: sequence/result configuration, sequencing and conversion counter of the converter.
 * assumes: adc_data is valid when a conversion completes; result file lives outside and
 * takes res_wr; trigger and freeze pins are asynchronous.
 */
module asr_seq_cfg #(
	parameter int RES_BITS = 10,
	parameter int NUM_RESULTS = 16,
	parameter int CONV_CYCLES = asr_pkg::CONV_CYCLES_DEF
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire asr_pkg::asr_apb_req_s apb_req,
	output logic [31:0] prdata_ff,
	output logic pready_ff,
	output logic pslverr_ff,
	// converter side
	input wire logic [RES_BITS-1:0] adc_data,
	input wire logic ext_trigger_pin,
	input wire logic debug_freeze_pin,
	output asr_pkg::asr_res_wr_s res_wr_ff,
	output logic [NUM_RESULTS-1:0] ccf_ff,
	output logic [3:0] conversion_counter_ff,
	output logic compare_irq_eff_ff,
	output logic [NUM_RESULTS-1:0] compare_en_eff_ff,
	output logic seq_done_ff,
	output logic busy_ff,
	output logic halted_ff
);

	generate
		if (RES_BITS < 8 || RES_BITS > 16 || NUM_RESULTS < 10 || NUM_RESULTS > 16) begin : g_bad
			$error("asr_seq_cfg: unsupported RES_BITS or NUM_RESULTS");
		end
	endgenerate

	// ************************************************
	// pin synchronisers
	// ************************************************
	logic [2:0] trig_sync_ff;
	logic [2:0] frz_sync_ff;
	logic trig_lvl_ff;
	logic frz_lvl_ff;
	logic trig_rise;
	logic freeze_req;

	// a change counts only once stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_sync_ff <= 3'h0;
			frz_sync_ff <= 3'h0;
			trig_lvl_ff <= 1'b0;
			frz_lvl_ff <= 1'b0;
		end else begin
			trig_sync_ff <= {trig_sync_ff[1:0], ext_trigger_pin};
			frz_sync_ff <= {frz_sync_ff[1:0], debug_freeze_pin};
			if (trig_sync_ff[1] == trig_sync_ff[2]) begin
				trig_lvl_ff <= trig_sync_ff[2];
			end
			if (frz_sync_ff[1] == frz_sync_ff[2]) begin
				frz_lvl_ff <= frz_sync_ff[2];
			end
		end
	end

	assign trig_rise = (trig_sync_ff[1] == trig_sync_ff[2]) && trig_sync_ff[2] && !trig_lvl_ff;
	assign freeze_req = frz_lvl_ff;

	// ************************************************
	// apb registers
	// ************************************************
	logic [7:0] cfg_ff, nxt_cfg;
	logic scan_ff, nxt_scan;
	logic [7:0] start_ff, nxt_start;
	logic [1:0] ctrl_ff, nxt_ctrl;
	logic [NUM_RESULTS-1:0] cmpen_ff, nxt_cmpen;
	logic [31:0] nxt_prdata;
	logic nxt_pready, nxt_pslverr;
	logic acc, wr_cfg, wr_start, wr_flags, mapped;
	logic [31:0] rd_data;
	asr_pkg::asr_state_e state_ff, nxt_state;
	logic fifo, ext_en;
	logic [1:0] halt_mode;

	assign acc = apb_req.psel && apb_req.penable && pready_ff;
	assign wr_cfg = acc && apb_req.pwrite && (apb_req.paddr == asr_pkg::CFG_ADDR);
	assign wr_start = acc && apb_req.pwrite && (apb_req.paddr == asr_pkg::START_ADDR);
	assign wr_flags = acc && apb_req.pwrite && (apb_req.paddr == asr_pkg::FLAGS_ADDR);
	assign fifo = cfg_ff[asr_pkg::CFG_FIFO_BIT];
	assign halt_mode = cfg_ff[asr_pkg::CFG_HALT_MSB:asr_pkg::CFG_HALT_LSB];
	assign ext_en = ctrl_ff[asr_pkg::CTRL_EXT_TRIG_BIT];

	always_comb begin
		rd_data = 32'h0;
		mapped = 1'b1;
		unique case (apb_req.paddr)
			asr_pkg::CFG_ADDR: rd_data[7:0] = cfg_ff;
			asr_pkg::START_ADDR: rd_data[7:0] = start_ff;
			asr_pkg::CTRL_ADDR: rd_data[1:0] = ctrl_ff;
			asr_pkg::CMPEN_ADDR: rd_data[NUM_RESULTS-1:0] = cmpen_ff;
			asr_pkg::STATUS_ADDR: begin
				rd_data[3:0] = conversion_counter_ff;
				rd_data[asr_pkg::STATUS_BUSY_BIT] = busy_ff;
				rd_data[asr_pkg::STATUS_HALT_BIT] = halted_ff;
			end
			asr_pkg::FLAGS_ADDR: rd_data[NUM_RESULTS-1:0] = ccf_ff;
			default: mapped = 1'b0;
		endcase
	end

	// one wait state: pready rises in the second access cycle
	always_comb begin
		nxt_pready = apb_req.psel && apb_req.penable && !pready_ff;
		nxt_pslverr = nxt_pready && !mapped;
		nxt_prdata = prdata_ff;
		if (nxt_pready) begin
			nxt_prdata = apb_req.pwrite ? 32'h0 : rd_data;
		end
		nxt_cfg = cfg_ff;
		nxt_start = start_ff;
		nxt_scan = scan_ff;
		nxt_ctrl = ctrl_ff;
		nxt_cmpen = cmpen_ff;
		if (wr_cfg) begin
			nxt_cfg = apb_req.pwdata[7:0];
		end
		if (wr_start) begin
			nxt_start = apb_req.pwdata[7:0];
			nxt_scan = apb_req.pwdata[asr_pkg::START_SCAN_BIT];
		end
		if (acc && apb_req.pwrite && apb_req.paddr == asr_pkg::CTRL_ADDR) begin
			nxt_ctrl = apb_req.pwdata[1:0];
		end
		if (acc && apb_req.pwrite && apb_req.paddr == asr_pkg::CMPEN_ADDR) begin
			nxt_cmpen = apb_req.pwdata[NUM_RESULTS-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			cfg_ff <= asr_pkg::CFG_RESET;
			start_ff <= 8'h0;
			scan_ff <= 1'b0;
			ctrl_ff <= 2'h0;
			cmpen_ff <= '0;
		end else begin
			prdata_ff <= nxt_prdata;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			cfg_ff <= nxt_cfg;
			start_ff <= nxt_start;
			scan_ff <= nxt_scan;
			ctrl_ff <= nxt_ctrl;
			cmpen_ff <= nxt_cmpen;
		end
	end

	// ************************************************
	// sequencer
	// ************************************************
	logic t_go, t_kill, t_hold, t_busy, t_done, frz_stop, last_conv;
	logic armed_ff, nxt_armed;
	logic [3:0] seq_pos_ff, nxt_seq_pos;
	logic [3:0] nxt_cc;
	asr_pkg::asr_res_wr_s nxt_res_wr;
	logic nxt_seq_done;
	logic [NUM_RESULTS-1:0] nxt_ccf, ccf_set;

	function automatic logic [15:0] justify(input logic [RES_BITS-1:0] raw, input logic right);
		justify = right ? 16'(raw) : 16'({raw, {(16 - RES_BITS){1'b0}}});
	endfunction : justify

	function automatic logic [3:0] cc_next(input logic [3:0] cc);
		cc_next = (cc == 4'(NUM_RESULTS - 1)) ? 4'h0 : cc + 4'h1;
	endfunction : cc_next

	// immediate freeze stops the timer; the after-conversion freeze only stops between conversions
	assign t_hold = (state_ff == asr_pkg::ASR_HALT) ||
		(freeze_req && halt_mode == asr_pkg::HALT_NOW);
	assign frz_stop = freeze_req && ((halt_mode == asr_pkg::HALT_NOW) ||
		(halt_mode == asr_pkg::HALT_AFTER_CONV && !t_busy));
	assign last_conv = (seq_pos_ff == asr_pkg::asr_seq_len(cfg_ff[6:3]) - 4'h1);

	always_comb begin
		nxt_state = state_ff;
		nxt_armed = armed_ff;
		nxt_seq_pos = seq_pos_ff;
		nxt_cc = conversion_counter_ff;
		nxt_res_wr = res_wr_ff;
		nxt_res_wr.valid = 1'b0;
		nxt_seq_done = 1'b0;
		t_go = 1'b0;
		t_kill = 1'b0;
		unique case (state_ff)
			asr_pkg::ASR_IDLE: begin
				if (trig_rise && ext_en && armed_ff) begin
					nxt_state = asr_pkg::ASR_RUN;
					nxt_seq_pos = 4'h0;
					if (!fifo) begin
						nxt_cc = 4'h0;
					end
				end
			end
			asr_pkg::ASR_RUN: begin
				if (t_done) begin
					nxt_res_wr.valid = 1'b1;
					nxt_res_wr.idx = conversion_counter_ff;
					nxt_res_wr.data = justify(adc_data, cfg_ff[asr_pkg::CFG_JUSTIFY_BIT]);
					nxt_cc = cc_next(conversion_counter_ff);
					nxt_seq_pos = seq_pos_ff + 4'h1;
					if (last_conv) begin
						nxt_seq_done = 1'b1;
						nxt_seq_pos = 4'h0;
						if (!fifo) begin
							nxt_cc = 4'h0;
						end
						if (!scan_ff || ext_en) begin
							nxt_state = asr_pkg::ASR_IDLE;
						end
					end
				end else if (frz_stop) begin
					nxt_state = asr_pkg::ASR_HALT;
				end else if (!t_busy) begin
					t_go = 1'b1;
				end
			end
			asr_pkg::ASR_HALT: begin
				if (!freeze_req || !halt_mode[1]) begin
					nxt_state = asr_pkg::ASR_RUN;
				end
			end
		endcase
		if (wr_cfg) begin
			t_kill = 1'b1;
			nxt_state = asr_pkg::ASR_IDLE;
			nxt_cc = 4'h0;
			nxt_seq_pos = 4'h0;
			nxt_res_wr.valid = 1'b0;
			nxt_seq_done = 1'b0;
		end
		if (wr_start) begin
			t_kill = 1'b1;
			nxt_armed = 1'b1;
			nxt_state = ext_en ? asr_pkg::ASR_IDLE : asr_pkg::ASR_RUN;
			nxt_cc = 4'h0;
			nxt_seq_pos = 4'h0;
			nxt_res_wr.valid = 1'b0;
			nxt_seq_done = 1'b0;
		end
	end

	// a flag being set wins over a clear in the same cycle
	always_comb begin
		ccf_set = '0;
		if (nxt_res_wr.valid) begin
			ccf_set[nxt_res_wr.idx] = 1'b1;
		end
		nxt_ccf = ccf_ff;
		if (wr_flags) begin
			nxt_ccf = ccf_ff & ~apb_req.pwdata[NUM_RESULTS-1:0];
		end
		nxt_ccf = nxt_ccf | ccf_set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= asr_pkg::ASR_IDLE;
			armed_ff <= 1'b0;
			seq_pos_ff <= 4'h0;
			conversion_counter_ff <= 4'h0;
			res_wr_ff <= '0;
			seq_done_ff <= 1'b0;
			ccf_ff <= '0;
			busy_ff <= 1'b0;
			halted_ff <= 1'b0;
			compare_irq_eff_ff <= 1'b0;
			compare_en_eff_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			armed_ff <= nxt_armed;
			seq_pos_ff <= nxt_seq_pos;
			conversion_counter_ff <= nxt_cc;
			res_wr_ff <= nxt_res_wr;
			seq_done_ff <= nxt_seq_done;
			ccf_ff <= nxt_ccf;
			busy_ff <= (nxt_state != asr_pkg::ASR_IDLE);
			halted_ff <= (nxt_state == asr_pkg::ASR_HALT);
			compare_irq_eff_ff <= ctrl_ff[asr_pkg::CTRL_CMP_IRQ_BIT] && !fifo;
			compare_en_eff_ff <= fifo ? '0 : cmpen_ff;
		end
	end

	asr_conv_timer #(.CYCLES(CONV_CYCLES)) u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.go(t_go),
		.hold(t_hold),
		.kill(t_kill),
		.busy(t_busy),
		.done(t_done)
	);

	// ************************************************
	// assertions
	// ************************************************
	a_cfg_abort: assert property (@(posedge pclk) disable iff (!presetn)
		wr_cfg |=> state_ff == asr_pkg::ASR_IDLE && conversion_counter_ff == 4'h0 && !t_busy)
		else $error("config write did not abort");
	a_justify_fmt: assert property (@(posedge pclk) disable iff (!presetn)
		res_wr_ff.valid |-> res_wr_ff.data == justify($past(adc_data), $past(cfg_ff[7])))
		else $error("result justification wrong");
	a_seq_length: assert property (@(posedge pclk) disable iff (!presetn)
		seq_done_ff |-> $past(seq_pos_ff) == asr_pkg::asr_seq_len($past(cfg_ff[6:3])) - 4'h1)
		else $error("sequence length wrong");
	a_reset_len: assert property (@(posedge pclk) disable iff (!presetn)
		!$past(presetn) |-> cfg_ff[6:3] == 4'h4)
		else $error("length field not four");
	a_fixed_slot: assert property (@(posedge pclk) disable iff (!presetn)
		res_wr_ff.valid && !$past(fifo) |-> res_wr_ff.idx == $past(seq_pos_ff))
		else $error("fixed placement slot wrong");
	a_fifo_wrap: assert property (@(posedge pclk) disable iff (!presetn)
		$past(t_done && fifo && !wr_cfg && !wr_start && state_ff == asr_pkg::ASR_RUN)
		|-> conversion_counter_ff == cc_next($past(conversion_counter_ff)))
		else $error("consecutive counter did not advance or wrap");
	a_status_cc: assert property (@(posedge pclk) disable iff (!presetn)
		nxt_pready && !apb_req.pwrite && apb_req.paddr == asr_pkg::STATUS_ADDR
		|=> prdata_ff[3:0] == $past(conversion_counter_ff))
		else $error("status counter mismatch");
	a_start_clear: assert property (@(posedge pclk) disable iff (!presetn)
		wr_start && !ext_en |=> conversion_counter_ff == 4'h0 && state_ff == asr_pkg::ASR_RUN)
		else $error("start did not clear and run");
	a_cmp_off: assert property (@(posedge pclk) disable iff (!presetn)
		fifo ##1 fifo |-> !compare_irq_eff_ff && compare_en_eff_ff == '0)
		else $error("compare not disabled");
	a_ccf_set: assert property (@(posedge pclk) disable iff (!presetn)
		res_wr_ff.valid |-> ccf_ff[res_wr_ff.idx])
		else $error("complete flag not set");
	a_freeze_now: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == asr_pkg::ASR_RUN && freeze_req && halt_mode == asr_pkg::HALT_NOW
		&& !t_done && !wr_cfg && !wr_start |=> state_ff == asr_pkg::ASR_HALT)
		else $error("immediate freeze missed");
	a_single_seq: assert property (@(posedge pclk) disable iff (!presetn)
		seq_done_ff && $past(!scan_ff || ext_en) |-> state_ff == asr_pkg::ASR_IDLE)
		else $error("single sequence did not stop");
	a_halt_keep: assert property (@(posedge pclk) disable iff (!presetn)
		$past(state_ff == asr_pkg::ASR_HALT && !wr_cfg && !wr_start)
		|-> $stable(conversion_counter_ff) && !res_wr_ff.valid)
		else $error("frozen state changed");

endmodule : asr_seq_cfg

// File: rtl/asr_pkg.sv
/*
 * asr_pkg: constants, types and register map of the sequence/result configuration block.
 * assumes: one bus clock domain, APB with 32-bit data, byte addresses on paddr.
 */
package asr_pkg;

	// ************************************************
	// register map (byte addresses)
	// ************************************************
	localparam int CFG_INDEX = 3;
	localparam int START_INDEX = 5;
	localparam logic [7:0] CFG_ADDR = 8'(CFG_INDEX * 4);
	localparam logic [7:0] START_ADDR = 8'(START_INDEX * 4);
	localparam logic [7:0] CTRL_ADDR = 8'h40;
	localparam logic [7:0] CMPEN_ADDR = 8'h44;
	localparam logic [7:0] STATUS_ADDR = 8'h48;
	localparam logic [7:0] FLAGS_ADDR = 8'h4c;

	// ************************************************
	// field positions and reset values
	// ************************************************
	localparam int CFG_JUSTIFY_BIT = 7;
	localparam int CFG_LEN_MSB = 6;
	localparam int CFG_LEN_LSB = 3;
	localparam int CFG_FIFO_BIT = 2;
	localparam int CFG_HALT_MSB = 1;
	localparam int CFG_HALT_LSB = 0;
	localparam logic [7:0] CFG_RESET = 8'h20;
	localparam int START_SCAN_BIT = 5;
	localparam int CTRL_EXT_TRIG_BIT = 0;
	localparam int CTRL_CMP_IRQ_BIT = 1;
	localparam int STATUS_BUSY_BIT = 4;
	localparam int STATUS_HALT_BIT = 5;
	localparam logic [3:0] SEQ_LEN_MAX = 4'ha;

	// freeze responses
	localparam logic [1:0] HALT_CONTINUE = 2'h0;
	localparam logic [1:0] HALT_RESERVED = 2'h1;
	localparam logic [1:0] HALT_AFTER_CONV = 2'h2;
	localparam logic [1:0] HALT_NOW = 2'h3;

	// ************************************************
	// timing
	// ************************************************
	localparam int CONV_CYCLES_DEF = 14;

	// ************************************************
	// types
	// ************************************************
	typedef enum logic [1:0] {ASR_IDLE, ASR_RUN, ASR_HALT} asr_state_e;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} asr_apb_req_s;

	typedef struct packed {
		logic valid;
		logic [3:0] idx;
		logic [15:0] data;
	} asr_res_wr_s;

	// value 0 and 10..15 all mean ten conversions
	function automatic logic [3:0] asr_seq_len(input logic [3:0] code);
		asr_seq_len = (code == 4'h0 || code > 4'h9) ? SEQ_LEN_MAX : code;
	endfunction : asr_seq_len

endpackage : asr_pkg

// File: rtl/asr_conv_timer.sv
/*
 * asr_conv_timer: times one conversion in bus clock cycles, can be held and killed.
 * assumes: go is only raised while idle; kill wins over go and hold.
 */
module asr_conv_timer #(
	parameter int CYCLES = asr_pkg::CONV_CYCLES_DEF
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic go,
	input wire logic hold,
	input wire logic kill,
	// status
	output logic busy,
	output logic done
);

	localparam int CW = $clog2(CYCLES + 1);

	// ************************************************
	// counter
	// ************************************************
	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;

	generate
		if (CYCLES < 2) begin : g_bad
			$error("asr_conv_timer: CYCLES must be at least 2");
		end
	endgenerate

	assign busy = (cnt_ff != '0);
	// a held conversion never completes, so an immediate freeze loses no result
	assign done = (cnt_ff == CW'(1)) && !hold && !kill;

	always_comb begin
		nxt_cnt = cnt_ff;
		if (kill) begin
			nxt_cnt = '0;
		end else if (go && !busy) begin
			nxt_cnt = CW'(CYCLES);
		end else if (busy && !hold) begin
			nxt_cnt = cnt_ff - CW'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

endmodule : asr_conv_timer

// File: testbench/asr_seq_cfg_tb_top.sv
/*
 * asr_seq_cfg_tb_top: self-checking bench for the sequence/result configuration block.
 * assumes: asr_pkg compiled first; the bench drives every port itself, one 100 MHz clock.
 */
module asr_seq_cfg_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// ************************************************
	// signals
	// ************************************************
	logic pclk;
	logic presetn;
	asr_pkg::asr_apb_req_s req;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [9:0] adc;
	logic trig;
	logic frz;
	asr_pkg::asr_res_wr_s res_wr_ff;
	logic [15:0] ccf_ff;
	logic [3:0] cc_ff;
	logic cmp_irq_ff;
	logic [15:0] cmp_en_ff;
	logic seq_done_ff;
	logic busy_ff;
	logic halted_ff;
	logic [19:0] res_q[$];
	logic [32:0] rd_q[$];
	int err_total = 0;
	int n_compared = 0;
	int cyc = 0;
	int n_done = 0;

	// conversions lengthened so an abort lands well between two results
	asr_seq_cfg #(.RES_BITS(10), .NUM_RESULTS(16), .CONV_CYCLES(20)) dut (
		.pclk(pclk), .presetn(presetn), .apb_req(req), .prdata_ff(prdata_ff),
		.pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .adc_data(adc),
		.ext_trigger_pin(trig), .debug_freeze_pin(frz), .res_wr_ff(res_wr_ff),
		.ccf_ff(ccf_ff), .conversion_counter_ff(cc_ff), .compare_irq_eff_ff(cmp_irq_ff),
		.compare_en_eff_ff(cmp_en_ff), .seq_done_ff(seq_done_ff), .busy_ff(busy_ff),
		.halted_ff(halted_ff));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// ************************************************
	// checking and closing
	// ************************************************
	task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s: expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic report_and_stop();
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : report_and_stop

	// watchdog: the whole run needs well under this many cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_total++;
			report_and_stop();
		end
	end

	// monitor: oldest note against each result write and each read answer
	always @(posedge pclk) begin
		if (seq_done_ff === 1'b1) begin
			n_done++;
		end
		if (res_wr_ff.valid === 1'b1) begin
			if (res_q.size() == 0) begin
				check("stray_result", 33'h1, 33'h0);
			end else begin
				check("result", {res_wr_ff.idx, res_wr_ff.data}, res_q.pop_front());
			end
		end
		if (pready_ff === 1'b1 && req.psel && req.penable && !req.pwrite) begin
			check("read", {pslverr_ff, prdata_ff}, rd_q.pop_front());
		end
	end

	// ************************************************
	// bus and sequence tasks
	// ************************************************
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge pclk);
		req.penable <= 1'b1;
		@(posedge pclk);
		while (pready_ff !== 1'b1) @(posedge pclk);
		req <= '0;
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [32:0] exp);
		rd_q.push_back(exp);
		apb(1'b0, a, 32'h0);
	endtask : rd

	task automatic wait_idle();
		repeat (2) @(posedge pclk);
		while (busy_ff !== 1'b0) @(negedge pclk);
		// two edges more, so the monitor has taken the last note before anyone looks
		repeat (2) @(posedge pclk);
	endtask : wait_idle

	task automatic wait_left(input int n);
		while (res_q.size() != n) @(negedge pclk);
		@(posedge pclk);
	endtask : wait_left

	// notes n results from slot s on, justified per j, with a fresh random sample
	task automatic expect_res(input int n, input int s, input logic j);
		logic [9:0] v;
		v = 10'($urandom());
		adc <= v;
		for (int i = 0; i < n; i++) begin
			res_q.push_back({4'((s + i) % 16), j ? {6'h0, v} : {v, 6'h0}});
		end
	endtask : expect_res

	// ************************************************
	// main sequence
	// ************************************************
	initial begin
		int n;
		logic [15:0] r;
		logic [7:0] c;
		req = '0;
		adc = '0;
		trig = 1'b0;
		frz = 1'b0;
		presetn = 1'b0;
		void'($urandom(76862));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd(asr_pkg::CFG_ADDR, 33'h20);
		rd(asr_pkg::STATUS_ADDR, 33'h0);
		rd(8'h80, {1'b1, 32'h0});

		// every length code, justification alternating, fixed placement
		for (int k = 0; k < 16; k++) begin
			n = (k == 0 || k > 9) ? 10 : k;
			c = {k[0], 4'(k), 3'h0};
			apb(1'b1, asr_pkg::CFG_ADDR, {24'h0, c});
			apb(1'b1, asr_pkg::FLAGS_ADDR, 32'hffff);
			rd(asr_pkg::CFG_ADDR, {25'h0, c});
			expect_res(n, 0, k[0]);
			apb(1'b1, asr_pkg::START_ADDR, 32'h0);
			wait_idle();
			check("seq_len", res_q.size(), 0);
			check("seq_done", n_done, k + 1);
			check("ccf_out", ccf_ff, 33'((1 << n) - 1));
			rd(asr_pkg::FLAGS_ADDR, 33'((1 << n) - 1));
		end

		// consecutive placement hides all compare enables
		r = 16'($urandom());
		apb(1'b1, asr_pkg::CTRL_ADDR, 32'h2);
		apb(1'b1, asr_pkg::CMPEN_ADDR, {16'h0, r});
		repeat (3) @(posedge pclk);
		check("cmp_irq", cmp_irq_ff, 1);
		check("cmp_en", cmp_en_ff, r);
		apb(1'b1, asr_pkg::CFG_ADDR, 32'h24);
		repeat (3) @(posedge pclk);
		check("cmp_irq_fifo", cmp_irq_ff, 0);
		check("cmp_en_fifo", cmp_en_ff, 0);
		apb(1'b1, asr_pkg::CTRL_ADDR, 32'h0);

		// single sequence keeps the counter; a new start clears it
		expect_res(4, 0, 1'b0);
		apb(1'b1, asr_pkg::START_ADDR, 32'h0);
		wait_idle();
		rd(asr_pkg::STATUS_ADDR, 33'h4);
		check("cc_out", cc_ff, 4);
		expect_res(4, 0, 1'b0);
		apb(1'b1, asr_pkg::START_ADDR, 32'h0);
		wait_idle();
		check("restart", res_q.size(), 0);

		// scanning wraps past the last slot, then a config write aborts
		expect_res(20, 0, 1'b0);
		apb(1'b1, asr_pkg::START_ADDR, 32'h20);
		wait_left(0);
		apb(1'b1, asr_pkg::CFG_ADDR, 32'ha4);
		repeat (3) @(posedge pclk);
		check("abort_busy", busy_ff, 0);
		rd(asr_pkg::STATUS_ADDR, 33'h0);

		// each trigger runs one sequence, counter carries on between them
		apb(1'b1, asr_pkg::CFG_ADDR, 32'h14);
		apb(1'b1, asr_pkg::CTRL_ADDR, 32'h1);
		apb(1'b1, asr_pkg::START_ADDR, 32'h20);
		for (int t = 0; t < 2; t++) begin
			expect_res(2, 2 * t, 1'b0);
			trig <= 1'b1;
			repeat (6) @(posedge pclk);
			trig <= 1'b0;
			wait_idle();
			check("trig_seq", res_q.size(), 0);
		end
		apb(1'b1, asr_pkg::CTRL_ADDR, 32'h0);

		// freeze codes: run on, finish then stop, stop at once; resume on release
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, asr_pkg::CFG_ADDR, {24'h0, 1'b1, 4'h3, 1'b0, 2'(m)});
			expect_res(3, 0, 1'b1);
			apb(1'b1, asr_pkg::START_ADDR, 32'h0);
			wait_left(2);
			frz <= 1'b1;
			repeat (60) @(posedge pclk);
			check("halted", halted_ff, (m >= 2));
			check("frozen_left", res_q.size(), (m == 3) ? 2 : (m == 2) ? 1 : 0);
			frz <= 1'b0;
			wait_idle();
			check("resumed", res_q.size(), 0);
		end
		report_and_stop();
	end
endmodule : asr_seq_cfg_tb_top
